// ### shared/apso_pkg.sv
package apso_pkg;

  // ---------------------------------------------------------------
  // widths and depths
  // ---------------------------------------------------------------
  localparam int CODE_W       = 15;
  localparam int RAW_W        = 17;
  localparam int SYNC_STAGES  = 3;
  localparam int PIPE_LATENCY = 3;
  localparam int BUF_DEPTH    = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_PERIOD_PS = 4000;
  localparam int STROBE_DELAY_PS   = 6500;
  localparam int STROBE_DELAY_CYC  =
    (STROBE_DELAY_PS + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
  localparam int DELAY_CNT_W       = 4;

  // ---------------------------------------------------------------
  // code values
  // ---------------------------------------------------------------
  localparam logic [14:0] CODE_RESET    = 15'h0000;
  localparam logic [14:0] CODE_POS_FULL = 15'h3fff;
  localparam logic [14:0] CODE_NEG_FULL = 15'h4000;
  localparam logic        FLAG_RESET    = 1'b0;
  localparam logic        STROBE_RESET  = 1'b0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        overrange;
    logic [14:0] code;
  } apso_sample_type;

  typedef struct packed {
    logic pos;
    logic neg;
  } apso_diff_type;

  localparam apso_sample_type SAMPLE_RESET = '{overrange: 1'b0, code: 15'h0000};
  localparam apso_diff_type   DIFF_RESET   = '{pos: 1'b0, neg: 1'b1};

endpackage

// ### src/apso_buffer.sv
`timescale 1ns/1ps
module apso_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic             do_push;
  logic             do_pop;

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] ptr);
    next_ptr = (ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(ptr + 1'b1);
  endfunction

  assign in_ready  = (count_q != CNT_W'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  // ---------------------------------------------------------------
  // pointers and fill level
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (do_pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      if (do_push && !do_pop) begin
        count_q <= CNT_W'(count_q + 1'b1);
      end else if (do_pop && !do_push) begin
        count_q <= CNT_W'(count_q - 1'b1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule

// ### src/apso_output_top.sv
`timescale 1ns/1ps
// Operation
// - the overrange flag goes high for a sample whose input exceeded full scale, else low.
// - each result appears on a 15-bit bus with bit 0 least and bit 14 most significant.
// - the data-valid strobe rises a set delay after each falling converter clock edge that hands a word out.
// - one input sample is taken on every rising edge of the converter clock unless a full buffer freezes the pipeline.
// - core results are corrected and formatted into a 15-bit two's-complement code.
// - the code of a sample is delivered three converter clock cycles after its sampling edge, four once a stall leaves a word buffered.
// - the code and flag are stable when the strobe rises, so capture on that edge is safe.
// - the overrange flag travels with the code of the same sample, timed exactly like it.
module apso_output_top (
  input  wire logic                              ref_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              conv_clock_pos,
  input  wire logic                              conv_clock_neg,
  input  wire logic signed [apso_pkg::RAW_W-1:0] raw_sample,
  input  wire logic                              capture_ready,
  output logic             [apso_pkg::CODE_W-1:0] out_code,
  output logic                                   overrange_flag,
  output logic                                   sample_valid_strobe
);

  localparam int LAT  = apso_pkg::PIPE_LATENCY;
  localparam int SW   = $bits(apso_pkg::apso_sample_type);
  localparam int EXTW = apso_pkg::RAW_W - apso_pkg::CODE_W;
  localparam int DCW  = apso_pkg::DELAY_CNT_W;
  localparam int PRW  = apso_pkg::SYNC_STAGES + 1;

  localparam logic signed [apso_pkg::RAW_W-1:0] RAW_MAX =
    $signed({{EXTW{1'b0}}, apso_pkg::CODE_POS_FULL});
  localparam logic signed [apso_pkg::RAW_W-1:0] RAW_MIN =
    $signed({{EXTW{1'b1}}, apso_pkg::CODE_NEG_FULL});
  localparam logic [DCW-1:0] DELAY_LOAD = DCW'(apso_pkg::STROBE_DELAY_CYC);
  localparam logic [DCW-1:0] DELAY_LAST = 4'h1;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // differential decode: a defined state only when the two legs disagree
  function automatic logic diff_level(input apso_pkg::apso_diff_type d,
                                      input logic                    hold);
    if (d.pos && !d.neg) begin
      diff_level = 1'b1;
    end else if (!d.pos && d.neg) begin
      diff_level = 1'b0;
    end else begin
      diff_level = hold;
    end
  endfunction

  // error-corrected core word to clipped 15-bit code plus overrange
  function automatic apso_pkg::apso_sample_type format_raw(
    input logic signed [apso_pkg::RAW_W-1:0] raw);
    apso_pkg::apso_sample_type s;
    s = apso_pkg::SAMPLE_RESET;
    if (raw > RAW_MAX) begin
      s.code      = apso_pkg::CODE_POS_FULL;
      s.overrange = 1'b1;
    end else if (raw < RAW_MIN) begin
      s.code      = apso_pkg::CODE_NEG_FULL;
      s.overrange = 1'b1;
    end else begin
      s.code      = raw[apso_pkg::CODE_W-1:0];
      s.overrange = 1'b0;
    end
    format_raw = s;
  endfunction

  // ---------------------------------------------------------------
  // converter clock synchroniser and edge finder
  // ---------------------------------------------------------------
  apso_pkg::apso_diff_type clk_s1_q;
  apso_pkg::apso_diff_type clk_s2_q;
  apso_pkg::apso_diff_type clk_s3_q;
  logic                    clk_lvl_q;
  logic                    clk_lvl_d;
  logic                    clk_agree;
  logic                    conv_rise;
  logic                    conv_fall;
  logic [PRW-1:0]          prime_q;
  logic                    primed;

  assign clk_agree = (clk_s2_q == clk_s3_q);
  assign clk_lvl_d = clk_agree ? diff_level(clk_s3_q, clk_lvl_q) : clk_lvl_q;
  // no edge counts until the chain holds real pin values, so a reset
  // released in the high phase does not show up as a false rise
  assign primed    = prime_q[PRW-1];
  assign conv_rise = primed & clk_lvl_d & ~clk_lvl_q;
  assign conv_fall = primed & ~clk_lvl_d & clk_lvl_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_s1_q  <= apso_pkg::DIFF_RESET;
      clk_s2_q  <= apso_pkg::DIFF_RESET;
      clk_s3_q  <= apso_pkg::DIFF_RESET;
      clk_lvl_q <= 1'b0;
      prime_q   <= '0;
    end else begin
      prime_q   <= {prime_q[PRW-2:0], 1'b1};
      clk_s1_q  <= '{pos: conv_clock_pos, neg: conv_clock_neg};
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
      clk_lvl_q <= clk_lvl_d;
    end
  end

  // ---------------------------------------------------------------
  // receiver ready synchroniser
  // ---------------------------------------------------------------
  logic rdy_s1_q;
  logic rdy_s2_q;
  logic rdy_s3_q;
  logic rdy_lvl_q;
  logic rdy_lvl_d;

  assign rdy_lvl_d = (rdy_s2_q == rdy_s3_q) ? rdy_s3_q : rdy_lvl_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_s1_q  <= 1'b0;
      rdy_s2_q  <= 1'b0;
      rdy_s3_q  <= 1'b0;
      rdy_lvl_q <= 1'b0;
    end else begin
      rdy_s1_q  <= capture_ready;
      rdy_s2_q  <= rdy_s1_q;
      rdy_s3_q  <= rdy_s2_q;
      rdy_lvl_q <= rdy_lvl_d;
    end
  end

  // ---------------------------------------------------------------
  // conversion pipeline
  // ---------------------------------------------------------------
  apso_pkg::apso_sample_type pipe_q [LAT];
  logic [LAT-1:0]            pipe_vld_q;
  apso_pkg::apso_sample_type fresh_sample;
  logic                      buf_in_ready;
  logic                      pipe_adv;
  logic                      buf_push;

  assign fresh_sample = format_raw(raw_sample);
  // a full buffer freezes the pipeline so no finished word is overwritten
  assign pipe_adv = conv_rise & (~pipe_vld_q[LAT-1] | buf_in_ready);
  assign buf_push = conv_rise & pipe_vld_q[LAT-1] & buf_in_ready;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pipe_vld_q <= '0;
    end else if (pipe_adv) begin
      pipe_vld_q <= {pipe_vld_q[LAT-2:0], 1'b1};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < LAT; i++) begin
        pipe_q[i] <= apso_pkg::SAMPLE_RESET;
      end
    end else if (pipe_adv) begin
      pipe_q[0] <= fresh_sample;
      for (int i = 1; i < LAT; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  // ---------------------------------------------------------------
  // output buffer
  // ---------------------------------------------------------------
  logic          buf_out_valid;
  logic [SW-1:0] buf_out_bits;
  logic          buf_pop;

  apso_pkg::apso_sample_type buf_out_data;

  assign buf_out_data = apso_pkg::apso_sample_type'(buf_out_bits);
  assign buf_pop      = conv_fall & buf_out_valid & rdy_lvl_q;

  apso_buffer #(
    .WIDTH (SW),
    .DEPTH (apso_pkg::BUF_DEPTH)
  ) u_buffer (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .in_valid  (buf_push),
    .in_data   (pipe_q[LAT-1]),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_bits),
    .out_ready (buf_pop)
  );

  // ---------------------------------------------------------------
  // output drivers and data-valid strobe
  // ---------------------------------------------------------------
  logic [apso_pkg::CODE_W-1:0] code_q;
  logic                        flag_q;
  logic                        strobe_q;
  logic                        strobe_d;
  logic [DCW-1:0]              dly_cnt_q;
  logic [DCW-1:0]              dly_cnt_d;

  assign dly_cnt_d = buf_pop ? DELAY_LOAD :
                     (dly_cnt_q != '0) ? DCW'(dly_cnt_q - 1'b1) : dly_cnt_q;
  // the strobe rises only after code and flag have settled, set wins over clear
  assign strobe_d  = (dly_cnt_q == DELAY_LAST) ? 1'b1 :
                     conv_rise ? 1'b0 : strobe_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_q    <= apso_pkg::CODE_RESET;
      flag_q    <= apso_pkg::FLAG_RESET;
      strobe_q  <= apso_pkg::STROBE_RESET;
      dly_cnt_q <= '0;
    end else begin
      if (buf_pop) begin
        code_q <= buf_out_data.code;
        flag_q <= buf_out_data.overrange;
      end
      strobe_q  <= strobe_d;
      dly_cnt_q <= dly_cnt_d;
    end
  end

  // bit 0 is the least significant line, bit 14 the most
  assign out_code            = code_q;
  assign overrange_flag      = flag_q;
  assign sample_valid_strobe = strobe_q;

endmodule

// ### tb/apso_output_properties.sv
`timescale 1ns/1ps
module apso_output_properties (
  input wire logic                        ref_clk,
  input wire logic                        sys_rst,
  input wire logic                        conv_clock_pos,
  input wire logic                        capture_ready,
  input wire logic [apso_pkg::CODE_W-1:0] out_code,
  input wire logic                        overrange_flag,
  input wire logic                        sample_valid_strobe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // strobe timing
  // ---------------------------------------------------------------
  a_strobe_after_fall: assert property (
    $rose(sample_valid_strobe) |-> !conv_clock_pos && !$past(conv_clock_pos, 4))
    else $error("strobe rose outside the low clock phase");
  a_load_to_strobe: assert property (
    $changed({overrange_flag, out_code}) |-> !sample_valid_strobe ##2 sample_valid_strobe)
    else $error("strobe not raised two cycles after a load");
  a_strobe_holds: assert property (
    $rose(sample_valid_strobe) |=> sample_valid_strobe [*8])
    else $error("strobe dropped early");
  a_strobe_clear: assert property (
    $rose(conv_clock_pos) |-> ##[1:8] !sample_valid_strobe)
    else $error("strobe not cleared after clock rise");
  // ---------------------------------------------------------------
  // data and flag
  // ---------------------------------------------------------------
  a_code_stable: assert property (
    sample_valid_strobe |-> $stable(out_code) && $stable(overrange_flag))
    else $error("code moved while strobe high");
  a_flag_clips: assert property (
    overrange_flag |-> out_code inside {15'h3fff, 15'h4000})
    else $error("flag high without full scale code");
  a_load_on_fall: assert property (
    $changed(out_code) |-> !conv_clock_pos)
    else $error("code loaded in high clock phase");
  a_no_pop_stalled: assert property (
    (!capture_ready) [*8] |-> !$rose(sample_valid_strobe))
    else $error("word handed out while receiver stalled");
  a_quiet_reset: assert property (
    $fell(sys_rst) |-> out_code == 15'h0000 && !overrange_flag && !sample_valid_strobe)
    else $error("outputs not idle after reset");
  cover property ($rose(sample_valid_strobe));
  cover property ($rose(overrange_flag));
  cover property ((!capture_ready) [*8]);
endmodule
bind apso_output_top apso_output_properties apso_output_properties_inst (
  .ref_clk            (ref_clk),
  .sys_rst            (sys_rst),
  .conv_clock_pos     (conv_clock_pos),
  .capture_ready      (capture_ready),
  .out_code           (out_code),
  .overrange_flag     (overrange_flag),
  .sample_valid_strobe(sample_valid_strobe)
);

// ### tb/apso_capture_model.sv
`timescale 1ns/1ps
module apso_capture_model (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic [apso_pkg::CODE_W-1:0] out_code,
  input  wire logic                        overrange_flag,
  input  wire logic                        sample_valid_strobe,
  input  wire logic                        stall,
  input  wire logic [31:0]                 rise_stamp,
  output logic                             capture_ready
);
  apso_pkg::apso_sample_type cap_q[$];
  int                        stamp_q[$];
  logic                      strobe_q = 1'b0;
  initial capture_ready = 1'b1;
  // latch the word on the strobe's rising edge, stamped with the clock rise count
  always @(posedge ref_clk) begin
    capture_ready <= !stall;
    strobe_q      <= sample_valid_strobe;
    if (!sys_rst && sample_valid_strobe && !strobe_q) begin
      cap_q.push_back('{overrange: overrange_flag, code: out_code});
      stamp_q.push_back(int'(rise_stamp));
    end
  end
endmodule

// ### tb/adc_parallel_sample_output_bench.sv
`timescale 1ns/1ps
module adc_parallel_sample_output_bench;
  logic                               ref_clk;
  logic                               sys_rst;
  logic                               conv_clock_pos;
  logic                               conv_clock_neg;
  logic signed [apso_pkg::RAW_W-1:0]  raw_sample = 17'h00000;
  logic                               capture_ready;
  logic        [apso_pkg::CODE_W-1:0] out_code;
  logic                               overrange_flag;
  logic                               sample_valid_strobe;
  logic                               stall = 1'b0;
  int                                 rise_cnt = 0;
  int                                 cycles = 0;
  int                                 num_errors = 0;
  int                                 checks = 0;
  apso_output_top apso_output_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .conv_clock_pos(conv_clock_pos), .conv_clock_neg(conv_clock_neg),
    .raw_sample(raw_sample), .capture_ready(capture_ready), .out_code(out_code),
    .overrange_flag(overrange_flag), .sample_valid_strobe(sample_valid_strobe));
  apso_capture_model apso_capture_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .out_code(out_code), .overrange_flag(overrange_flag), .stall(stall),
    .sample_valid_strobe(sample_valid_strobe), .rise_stamp(rise_cnt),
    .capture_ready(capture_ready));
  // ---------------------------------------------------------------
  // clocks and sample source
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // converter clock stands still through reset, then runs with its own phase
  initial begin
    conv_clock_pos = 1'b0;
    conv_clock_neg = 1'b1;
    #100.3;
    forever begin
      #80 conv_clock_pos = ~conv_clock_pos;
      conv_clock_neg = ~conv_clock_pos;
    end
  end
  always @(posedge conv_clock_pos) rise_cnt <= rise_cnt + 1;
  always @(posedge ref_clk) raw_sample <= sample_of(rise_cnt);
  function automatic logic signed [apso_pkg::RAW_W-1:0] sample_of(input int k);
    case (k % 8)
      0: return 17'h03fff;
      1: return 17'h04000;
      2: return 17'h1c000;
      3: return 17'h1bfff;
      4: return 17'h00000;
      5: return 17'h1ffff;
      6: return 17'h02aaa;
      default: return 17'h1d555;
    endcase
  endfunction
  function automatic apso_pkg::apso_sample_type expect_of(input int k);
    logic signed [apso_pkg::RAW_W-1:0] r;
    r = sample_of(k);
    if (r > 17'sh03fff) return '{overrange: 1'b1, code: 15'h3fff};
    if (r < 17'sh1c000) return '{overrange: 1'b1, code: 15'h4000};
    return '{overrange: 1'b0, code: r[14:0]};
  endfunction
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_caps(input int n);
    for (int i = 0; i < 4000 && apso_capture_model_inst.cap_q.size() < n; i++) begin
      @(posedge ref_clk);
    end
    check("capture count reached", apso_capture_model_inst.cap_q.size() >= n, 1);
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic stream_in_order;
    wait_caps(10);
    for (int n = 0; n < 10; n++) begin
      check("code", apso_capture_model_inst.cap_q[n], expect_of(n + 1));
      check("rise count", apso_capture_model_inst.stamp_q[n], n + 4);
    end
  endtask
  task automatic stall_and_drain;
    int c;
    int k;
    stall <= 1'b1;
    repeat (40) @(posedge ref_clk);
    c = apso_capture_model_inst.cap_q.size();
    repeat (240) @(posedge ref_clk);
    check("stalled captures", apso_capture_model_inst.cap_q.size(), c);
    stall <= 1'b0;
    wait_caps(c + 10);
    // after a stall the buffer keeps one word, so a drained word trails its rise by four
    for (int n = c + 7; n < c + 10; n++) begin
      k = apso_capture_model_inst.stamp_q[n] - 4;
      check("drained code", apso_capture_model_inst.cap_q[n], expect_of(k));
    end
  endtask
  task automatic reset_mid_run;
    int c;
    int k;
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("outputs in reset", {out_code, overrange_flag, sample_valid_strobe}, 0);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("strobe after reset", sample_valid_strobe, 0);
    // an emptied pipeline restarts with the plain three-rise latency
    c = apso_capture_model_inst.cap_q.size();
    wait_caps(c + 2);
    k = apso_capture_model_inst.stamp_q[c] - 3;
    check("code after reset", apso_capture_model_inst.cap_q[c], expect_of(k));
  endtask
  initial begin
    sys_rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    stream_in_order;
    stall_and_drain;
    reset_mid_run;
    end_of_test;
  end
endmodule
